// ===== sfsr_pkg.sv
// Constants, field layout and carrier types for the serial flash status readout.
// Assumes a single 250 MHz system clock; the serial pins are sampled by it.
package sfsr_pkg;

  localparam logic [7:0] OPC_READ_STATUS = 8'h05;

  localparam int unsigned B1_LOCK   = 7;
  localparam int unsigned B1_ERR    = 5;
  localparam int unsigned B1_WPP    = 4;
  localparam int unsigned B1_SWP_HI = 3;
  localparam int unsigned B1_SWP_LO = 2;
  localparam int unsigned B1_WEL    = 1;
  localparam int unsigned BX_BUSY   = 0;
  localparam int unsigned B2_RSTEN  = 4;
  localparam int unsigned B2_LCKEN  = 3;
  localparam int unsigned B2_PSUS   = 2;
  localparam int unsigned B2_ESUS   = 1;

  localparam logic LOCK_RST  = 1'h0;
  localparam logic ERR_RST   = 1'h0;
  localparam logic WEL_RST   = 1'h0;
  localparam logic RSTEN_RST = 1'h0;
  localparam logic LCKEN_RST = 1'h0;

  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [2:0] BIT_LSB = 3'h0;

  typedef enum logic [1:0] {
    ST_OPCODE,
    ST_STATUS,
    ST_IGNORE
  } sfsr_state_e;

  typedef struct packed {
    logic       busy;
    logic       progSusp;
    logic       eraseSusp;
    logic [1:0] swProt;
  } sfsr_core_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sfsr_wr_s;

  typedef struct packed {
    logic done;
    logic failed;
  } sfsr_op_s;

endpackage

// ===== sfsr_status_read.sv
// Status byte pair of a serial flash: storage of the writable bits and the
// serial readout engine for the read-status opcode.
// Assumes the serial pins are asynchronous to sys_clk and that core status,
// operation results and write strobes come from logic on sys_clk.
//
// Function
// - Status read is accepted any time, also during program or erase.
// - After opcode 05h the device drives a status bit every clock.
// - After byte two the sequence restarts with byte one while selected.
// - Every repetition carries freshly sampled status values.
// - Busy flag appears in both bytes and is resampled per byte.
// - Above rated clock host reads four bytes and uses the later pair.
// - Deselect at any time ends the read and floats the output.
// - Byte one bit 7 is the writable protection lock, default unlocked.
// - Reserved bits read as zero: byte one bit 6, byte two 7:5.
// - Byte one bit 5 is the program or erase error flag.
// - Byte one bit 4 reads 0 while protect pin asserted, else 1.
// - Byte one bits 3:2 summarise software protection, default all.
// - Byte one bit 1 shows the write enable latch, default 0.
// - Bit 0 of each byte is busy: 1 while an operation runs.
// - Writing byte one changes only bit 7.
// - Byte two bit 4 is the writable reset command enable, default 0.
// - Byte two bit 3 is the writable lockdown command enable, default 0.
// - Byte two bits 2 and 1 show program and erase suspend.
// - Writing byte two changes only bits 4 and 3.
// - With protect pin asserted the lock may only go from 0 to 1.
// - Error flag refreshed after each operation, never set by an abort.
// - Write enable latch clears at reset and when a write command ends, unless set in the same cycle.
`timescale 1ns/10ps

module sfsr_status_read (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                spiSck,
  input  wire logic                spiCsN,
  input  wire logic                spiMosi,
  input  wire logic                protectPinN,
  input  wire sfsr_pkg::sfsr_core_s coreStatus,
  input  wire sfsr_pkg::sfsr_op_s  opResult,
  input  wire logic                wrenSet,
  input  wire logic                writeCmdEnd,
  input  wire sfsr_pkg::sfsr_wr_s  statWr1,
  input  wire sfsr_pkg::sfsr_wr_s  statWr2,
  output logic                     spiMiso,
  output logic                     spiMisoOe,
  output logic                     protectionLock,
  output logic                     programErrorFlag,
  output logic                     writeEnableLatch,
  output logic                     resetCmdEnable,
  output logic                     lockdownCmdEnable
);

  logic                  sckA_q;
  logic                  sckS_q;
  logic                  sckD_q;
  logic                  csA_q;
  logic                  csS_q;
  logic                  mosiA_q;
  logic                  mosiS_q;
  logic                  wpA_q;
  logic                  wpS_q;
  logic                  sckRise;
  logic                  sckFall;
  logic                  deselected;
  sfsr_pkg::sfsr_state_e state_q;
  logic [2:0]            inBit_q;
  logic [6:0]            opShift_q;
  logic [7:0]            opcodeFull;
  logic                  opcodeDone;
  logic [2:0]            outBit_q;
  logic                  byteSel_q;
  logic [7:0]            outByte_q;
  logic                  miso_q;
  logic                  oe_q;
  logic                  lock_q;
  logic                  err_q;
  logic                  wel_q;
  logic                  rstEn_q;
  logic                  lckEn_q;
  logic [7:0]            freshByte1;
  logic [7:0]            freshByte2;
  logic [7:0]            freshSel;

  // Pins cross into sys_clk through two flops; the second stage is read, and sck has a third flop for edge detection.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sckA_q  <= 1'h0;
      sckS_q  <= 1'h0;
      sckD_q  <= 1'h0;
      csA_q   <= 1'h1;
      csS_q   <= 1'h1;
      mosiA_q <= 1'h0;
      mosiS_q <= 1'h0;
      wpA_q   <= 1'h1;
      wpS_q   <= 1'h1;
    end else begin
      sckA_q  <= spiSck;
      sckS_q  <= sckA_q;
      sckD_q  <= sckS_q;
      csA_q   <= spiCsN;
      csS_q   <= csA_q;
      mosiA_q <= spiMosi;
      mosiS_q <= mosiA_q;
      wpA_q   <= protectPinN;
      wpS_q   <= wpA_q;
    end
  end

  assign sckRise    = sckS_q & ~sckD_q;
  assign sckFall    = ~sckS_q & sckD_q;
  assign deselected = csS_q;
  assign opcodeFull = {opShift_q, mosiS_q};
  assign opcodeDone = ~deselected & sckRise & (state_q == sfsr_pkg::ST_OPCODE) & (inBit_q == sfsr_pkg::BIT_MSB);

  // Status is assembled combinationally, so every byte reflects the core now.
  always_comb begin
    freshByte1                                       = 8'h00;
    freshByte1[sfsr_pkg::B1_LOCK]                    = lock_q;
    freshByte1[sfsr_pkg::B1_ERR]                     = err_q;
    freshByte1[sfsr_pkg::B1_WPP]                     = wpS_q;
    freshByte1[sfsr_pkg::B1_SWP_HI:sfsr_pkg::B1_SWP_LO] = coreStatus.swProt;
    freshByte1[sfsr_pkg::B1_WEL]                     = wel_q;
    freshByte1[sfsr_pkg::BX_BUSY]                    = coreStatus.busy;
    freshByte2                                       = 8'h00;
    freshByte2[sfsr_pkg::B2_RSTEN]                   = rstEn_q;
    freshByte2[sfsr_pkg::B2_LCKEN]                   = lckEn_q;
    freshByte2[sfsr_pkg::B2_PSUS]                    = coreStatus.progSusp;
    freshByte2[sfsr_pkg::B2_ESUS]                    = coreStatus.eraseSusp;
    freshByte2[sfsr_pkg::BX_BUSY]                    = coreStatus.busy;
    freshSel                                         = byteSel_q ? freshByte2 : freshByte1;
  end

  // Command phase: opcode bits are taken on rising serial clock edges.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q   <= sfsr_pkg::ST_OPCODE;
      inBit_q   <= sfsr_pkg::BIT_LSB;
      opShift_q <= 7'h00;
    end else if (deselected) begin
      state_q   <= sfsr_pkg::ST_OPCODE;
      inBit_q   <= sfsr_pkg::BIT_LSB;
      opShift_q <= 7'h00;
    end else if (sckRise && state_q == sfsr_pkg::ST_OPCODE) begin
      opShift_q <= opcodeFull[6:0];
      inBit_q   <= inBit_q + 3'h1;
      if (opcodeDone) begin
        // Busy does not gate this path, so polling works mid-operation.
        state_q <= (opcodeFull == sfsr_pkg::OPC_READ_STATUS) ? sfsr_pkg::ST_STATUS : sfsr_pkg::ST_IGNORE;
      end
    end
  end

  // Output phase: bits change on falling edges so they are stable at the rise.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outBit_q  <= sfsr_pkg::BIT_MSB;
      byteSel_q <= 1'h0;
      outByte_q <= 8'h00;
      miso_q    <= 1'h0;
      oe_q      <= 1'h0;
    end else if (deselected || state_q != sfsr_pkg::ST_STATUS) begin
      outBit_q  <= sfsr_pkg::BIT_MSB;
      byteSel_q <= 1'h0;
      miso_q    <= 1'h0;
      oe_q      <= 1'h0;
    end else if (sckFall) begin
      oe_q <= 1'h1;
      if (outBit_q == sfsr_pkg::BIT_MSB) begin
        // Resampled at each byte start; the first pair is as good as later ones at this rate.
        outByte_q <= freshSel;
        miso_q    <= freshSel[sfsr_pkg::BIT_MSB];
        outBit_q  <= outBit_q - 3'h1;
      end else begin
        miso_q   <= outByte_q[outBit_q];
        outBit_q <= outBit_q - 3'h1;
        if (outBit_q == sfsr_pkg::BIT_LSB) begin
          byteSel_q <= ~byteSel_q;
        end
      end
    end
  end

  // Writable bits of byte one: only the lock is touched.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lock_q <= sfsr_pkg::LOCK_RST;
    end else if (statWr1.valid) begin
      if (wpS_q) begin
        lock_q <= statWr1.data[sfsr_pkg::B1_LOCK];
      end else begin
        lock_q <= lock_q | statWr1.data[sfsr_pkg::B1_LOCK];
      end
    end
  end

  // Writable bits of byte two.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rstEn_q <= sfsr_pkg::RSTEN_RST;
      lckEn_q <= sfsr_pkg::LCKEN_RST;
    end else if (statWr2.valid) begin
      rstEn_q <= statWr2.data[sfsr_pkg::B2_RSTEN];
      lckEn_q <= statWr2.data[sfsr_pkg::B2_LCKEN];
    end
  end

  // An abort never reports done, so it leaves the previous result standing.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_q <= sfsr_pkg::ERR_RST;
    end else if (opResult.done) begin
      err_q <= opResult.failed;
    end
  end

  // A set that meets a clear in one cycle wins, so an enable is never lost.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wel_q <= sfsr_pkg::WEL_RST;
    end else if (wrenSet) begin
      wel_q <= 1'h1;
    end else if (writeCmdEnd) begin
      wel_q <= 1'h0;
    end
  end

  assign spiMiso           = miso_q;
  assign spiMisoOe         = oe_q;
  assign protectionLock    = lock_q;
  assign programErrorFlag  = err_q;
  assign writeEnableLatch  = wel_q;
  assign resetCmdEnable    = rstEn_q;
  assign lockdownCmdEnable = lckEn_q;

  AST_DESELECT_FLOAT: assert property (@(posedge sys_clk) disable iff (rst)
    deselected |=> !spiMisoOe && state_q == sfsr_pkg::ST_OPCODE)
    else $error("output not released after deselect");

  AST_READ_WHILE_BUSY: assert property (@(posedge sys_clk) disable iff (rst)
    opcodeDone && opcodeFull == sfsr_pkg::OPC_READ_STATUS && coreStatus.busy |=> state_q == sfsr_pkg::ST_STATUS)
    else $error("status read refused while busy");

  AST_DRIVE_EACH_CLOCK: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == sfsr_pkg::ST_STATUS && !deselected && sckFall |=> spiMisoOe)
    else $error("status bit not driven");

  AST_ALTERNATE: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == sfsr_pkg::ST_STATUS && !deselected && sckFall && outBit_q == sfsr_pkg::BIT_LSB
    |=> byteSel_q != $past(byteSel_q) && outBit_q == sfsr_pkg::BIT_MSB)
    else $error("byte sequence did not alternate");

  AST_FRESH_MSB: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == sfsr_pkg::ST_STATUS && !deselected && sckFall && outBit_q == sfsr_pkg::BIT_MSB
    |=> spiMiso == $past(freshSel[7]) && outByte_q == $past(freshSel))
    else $error("byte not freshly sampled at start");

  AST_BUSY_BOTH: assert property (@(posedge sys_clk) disable iff (rst)
    freshByte1[0] == coreStatus.busy && freshByte2[0] == coreStatus.busy)
    else $error("busy missing from a status byte");

  AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
    freshByte1[6] == 1'b0 && freshByte2[7:5] == 3'b000)
    else $error("reserved status bit not zero");

  AST_WPP_FOLLOWS: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(wpS_q) |-> freshByte1[4] == 1'b0)
    else $error("protect pin state wrong");

  AST_LOCK_HELD: assert property (@(posedge sys_clk) disable iff (rst)
    statWr1.valid && !wpS_q && lock_q |=> lock_q)
    else $error("lock cleared while protect pin asserted");

  AST_ERR_REFRESH: assert property (@(posedge sys_clk) disable iff (rst)
    opResult.done |=> programErrorFlag == $past(opResult.failed))
    else $error("error flag not refreshed");

  AST_WEL_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    writeCmdEnd && !wrenSet |=> !writeEnableLatch)
    else $error("write enable latch not cleared");

  AST_WR2_FIELDS: assert property (@(posedge sys_clk) disable iff (rst)
    statWr2.valid |=> resetCmdEnable == $past(statWr2.data[4]) && lockdownCmdEnable == $past(statWr2.data[3]))
    else $error("byte two write wrong");

endmodule

// ===== sfsr_host_model.sv
// Host side of the serial link: a mode 0 controller that shifts an opcode and collects reply bits.
// Assumes sys_clk from the bench; each serial half period is 8 sys_clk cycles, 64 ns a period.
`timescale 1ns/10ps

module sfsr_host_model (
  input  wire logic sys_clk,
  input  wire logic spiMiso,
  input  wire logic spiMisoOe,
  output logic      spiSck,
  output logic      spiCsN,
  output logic      spiMosi
);
  initial begin
    spiSck  = 1'b0;
    spiCsN  = 1'b1;
    spiMosi = 1'b0;
  end

  task automatic half();
    repeat (8) @(posedge sys_clk);
  endtask

  // Data beyond the opcode toggles every bit, so a device that wrongly samples it sees no steady level.
  task automatic xfer(input logic [7:0] opc, input int nBits, output logic [31:0] rx, output logic [7:0] oeCnt);
    rx = 32'h0000_0000;
    oeCnt = 8'h00;
    @(posedge sys_clk);
    spiCsN <= 1'b0;
    for (int i = 0; i < 8 + nBits; i++) begin
      spiMosi <= (i < 8) ? opc[7 - i] : ~spiMosi;
      half();
      spiSck <= 1'b1;
      if (i >= 8) begin
        // A released output has no pull, so the model shows the inverse and an undriven bit mismatches.
        rx = {rx[30:0], spiMisoOe ? spiMiso : ~spiMiso};
        oeCnt = oeCnt + spiMisoOe;
      end
      half();
      spiSck <= 1'b0;
    end
    half();
    spiCsN  <= 1'b1;
    spiMosi <= ~spiMosi;
  endtask
endmodule

// ===== sfsr_status_read_tb_top.sv
// Self-checking bench for the status readout: serial reads through the host model, strobes direct.
// Assumes the design registers strobe effects within two sys_clk edges of the strobe.
`timescale 1ns/10ps

module sfsr_status_read_tb_top;
  logic                 sys_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 spiSck, spiCsN, spiMosi, spiMiso, spiMisoOe;
  logic                 protectPinN = 1'b1, wrenSet = 1'b0, writeCmdEnd = 1'b0;
  logic                 protectionLock, programErrorFlag, writeEnableLatch, resetCmdEnable, lockdownCmdEnable;
  logic                 eLock = 1'b0, eErr = 1'b0, eWel = 1'b0, eRst = 1'b0, eLck = 1'b0;
  sfsr_pkg::sfsr_core_s coreStatus = '0;
  sfsr_pkg::sfsr_op_s   opResult = '0;
  sfsr_pkg::sfsr_wr_s   statWr1 = '0, statWr2 = '0;
  int                   n_fail = 0, checks = 0;

  always #2 sys_clk = ~sys_clk;

  sfsr_status_read i_sfsr_status_read (.sys_clk(sys_clk), .rst(rst), .spiSck(spiSck), .spiCsN(spiCsN),
    .spiMosi(spiMosi), .protectPinN(protectPinN), .coreStatus(coreStatus), .opResult(opResult),
    .wrenSet(wrenSet), .writeCmdEnd(writeCmdEnd), .statWr1(statWr1), .statWr2(statWr2), .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe), .protectionLock(protectionLock), .programErrorFlag(programErrorFlag),
    .writeEnableLatch(writeEnableLatch), .resetCmdEnable(resetCmdEnable), .lockdownCmdEnable(lockdownCmdEnable));

  sfsr_host_model i_sfsr_host_model (.sys_clk(sys_clk), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .spiSck(spiSck), .spiCsN(spiCsN), .spiMosi(spiMosi));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] expPair();
    return {eLock, 1'b0, eErr, protectPinN, coreStatus.swProt, eWel, coreStatus.busy,
            3'b000, eRst, eLck, coreStatus.progSusp, coreStatus.eraseSusp, coreStatus.busy};
  endfunction

  task automatic offChk();
    repeat (8) @(posedge sys_clk);
    chk("oeAfterDeselect", spiMisoOe, 1'b0);
  endtask

  // Four bytes are read so that a repeat of the pair is seen as well as the first pair.
  task automatic readChk();
    logic [31:0] rx;
    logic [7:0]  oeCnt;
    i_sfsr_host_model.xfer(sfsr_pkg::OPC_READ_STATUS, 32, rx, oeCnt);
    chk("statusWords", rx, {2{expPair()}});
    chk("oeCount", oeCnt, 8'h20);
    offChk();
  endtask

  task automatic evt(input sfsr_pkg::sfsr_wr_s w1, input sfsr_pkg::sfsr_wr_s w2, input sfsr_pkg::sfsr_op_s op,
                     input logic ws, input logic we);
    // Three edges let a protect pin change made just before the call pass the synchroniser first.
    repeat (3) @(posedge sys_clk);
    statWr1     <= w1;
    statWr2     <= w2;
    opResult    <= op;
    wrenSet     <= ws;
    writeCmdEnd <= we;
    @(posedge sys_clk);
    statWr1     <= '0;
    statWr2     <= '0;
    opResult    <= '0;
    wrenSet     <= 1'b0;
    writeCmdEnd <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("lock", protectionLock, eLock);
    chk("err", programErrorFlag, eErr);
    chk("wel", writeEnableLatch, eWel);
    chk("rsten", resetCmdEnable, eRst);
    chk("lcken", lockdownCmdEnable, eLck);
    @(posedge sys_clk);
  endtask

  task automatic testReset();
    evt('0, '0, '0, 1'b0, 1'b0);
    chk("oeIdle", spiMisoOe, 1'b0);
    $display("test reset done");
  endtask

  task automatic testRead();
    coreStatus <= '{busy: 1'b1, progSusp: 1'b1, eraseSusp: 1'b0, swProt: 2'b11};
    readChk();
    protectPinN <= 1'b0;
    coreStatus  <= '{busy: 1'b0, progSusp: 1'b0, eraseSusp: 1'b1, swProt: 2'b10};
    readChk();
    protectPinN <= 1'b1;
    $display("test read done");
  endtask

  task automatic testWrites();
    eLock = 1'b1;
    evt({1'b1, 8'hFF}, '0, '0, 1'b0, 1'b0);
    protectPinN <= 1'b0;
    evt({1'b1, 8'h00}, '0, '0, 1'b0, 1'b0);
    protectPinN <= 1'b1;
    eLock = 1'b0;
    evt({1'b1, 8'h7F}, '0, '0, 1'b0, 1'b0);
    protectPinN <= 1'b0;
    eLock = 1'b1;
    evt({1'b1, 8'h80}, '0, '0, 1'b0, 1'b0);
    eRst = 1'b1;
    eLck = 1'b1;
    evt('0, {1'b1, 8'hFF}, '0, 1'b0, 1'b0);
    readChk();
    eRst = 1'b0;
    evt('0, {1'b1, 8'h08}, '0, 1'b0, 1'b0);
    eRst = 1'b1;
    eLck = 1'b0;
    evt('0, {1'b1, 8'h10}, '0, 1'b0, 1'b0);
    protectPinN <= 1'b1;
    $display("test writes done");
  endtask

  task automatic testEvents();
    eWel = 1'b1;
    evt('0, '0, '0, 1'b1, 1'b0);
    eWel = 1'b0;
    evt('0, '0, '0, 1'b0, 1'b1);
    eWel = 1'b1;
    evt('0, '0, '0, 1'b1, 1'b1);
    evt('0, '0, 2'b01, 1'b0, 1'b0);
    eErr = 1'b1;
    evt('0, '0, 2'b11, 1'b0, 1'b0);
    readChk();
    eErr = 1'b0;
    evt('0, '0, 2'b10, 1'b0, 1'b0);
    $display("test events done");
  endtask

  // Status changes between the first and second byte, so a snapshot at the opcode would show old values.
  task automatic testLive();
    logic [31:0] rx;
    logic [7:0]  oeCnt;
    logic [15:0] oldPair;
    logic [15:0] newPair;
    coreStatus <= '{busy: 1'b1, progSusp: 1'b0, eraseSusp: 1'b0, swProt: 2'b11};
    @(posedge sys_clk);
    oldPair = expPair();
    fork
      i_sfsr_host_model.xfer(sfsr_pkg::OPC_READ_STATUS, 32, rx, oeCnt);
      begin
        repeat (200) @(posedge sys_clk);
        coreStatus.busy   <= 1'b0;
        coreStatus.swProt <= 2'b01;
      end
    join
    newPair = expPair();
    chk("liveWords", rx, {oldPair[15:8], newPair[7:0], newPair});
    offChk();
    $display("test live done");
  endtask

  task automatic testRefuse();
    logic [31:0] rx;
    logic [7:0]  oeCnt;
    logic [15:0] pair;
    i_sfsr_host_model.xfer(8'h9F, 16, rx, oeCnt);
    chk("oeOtherOpcode", oeCnt, 8'h00);
    offChk();
    i_sfsr_host_model.xfer(sfsr_pkg::OPC_READ_STATUS, 12, rx, oeCnt);
    pair = expPair();
    chk("partialWord", rx, {20'h0_0000, pair[15:4]});
    offChk();
    $display("test refuse done");
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    testReset();
    testRead();
    testWrites();
    testEvents();
    testLive();
    testRefuse();
    results();
  end
endmodule
